/* rtl/cbsc_arb_if.sv */
// Request and grant wires between the control word and its arbiter.
// Assumes both ends run on the same clock.
interface cbsc_arb_if;
  logic eng_valid;
  logic cpu_req;
  logic eng_grant;
  logic cpu_grant;

  modport arb (input eng_valid, input cpu_req, output eng_grant, output cpu_grant);
  modport top (output eng_valid, output cpu_req, input eng_grant, input cpu_grant);
endinterface : cbsc_arb_if

/* rtl/cbsc_arbiter.sv */
// Access arbiter for the shared control word.
// Assumes the CPU holds its request until acknowledged.
module cbsc_arbiter (
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  cbsc_arb_if.arb  bus
);

  logic hold;
  logic grant_cpu;

  // Engine always wins; the CPU waits, as in a dual-ported RAM stall
  assign bus.eng_grant = bus.eng_valid;
  // Request is still high in the ack cycle, so skip one cycle after a grant
  assign grant_cpu     = bus.cpu_req & ~bus.eng_valid & ~hold;
  assign bus.cpu_grant = grant_cpu;

  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      hold <= 1'b0;
    end else begin
      hold <= grant_cpu;
    end
  end

endmodule : cbsc_arbiter

/* rtl/cbsc_engine_next.sv */
// Next buffer state for an engine command.
// Assumes commands arrive only from the protocol engine.
module cbsc_engine_next (
  input  wire cbsc_pkg::cbsc_state_type i_state,
  input  wire cbsc_pkg::cbsc_cmd_type   i_cmd,
  output cbsc_pkg::cbsc_state_type      o_next,
  output logic                          o_update,
  output logic                          o_dlc_write
);

  always_comb begin
    o_next      = i_state;
    o_update    = 1'b0;
    o_dlc_write = 1'b0;
    case (i_cmd)
      cbsc_pkg::cmd_copy_start: begin
        o_update = 1'b1;
        case (i_state)
          cbsc_pkg::st_rx_armed:   o_next = cbsc_pkg::st_rx_copy_first;
          cbsc_pkg::st_rx_holding: o_next = cbsc_pkg::st_rx_copy_second;
          cbsc_pkg::st_rx_lost:    o_next = cbsc_pkg::st_rx_copy_later;
          default:                 o_update = 1'b0;
        endcase
      end
      cbsc_pkg::cmd_copy_done: begin
        o_update    = 1'b1;
        o_dlc_write = 1'b1;
        case (i_state)
          cbsc_pkg::st_rx_copy_first:  o_next = cbsc_pkg::st_rx_holding;
          cbsc_pkg::st_rx_copy_second: o_next = cbsc_pkg::st_rx_lost;
          cbsc_pkg::st_rx_copy_later:  o_next = cbsc_pkg::st_rx_lost;
          cbsc_pkg::st_rx_cancelled:   o_next = cbsc_pkg::st_rx_idle;
          default: begin
            o_update    = 1'b0;
            o_dlc_write = 1'b0;
          end
        endcase
      end
      cbsc_pkg::cmd_tx_schedule: begin
        o_update = 1'b1;
        case (i_state)
          cbsc_pkg::st_tx_single:      o_next = cbsc_pkg::st_tx_busy_a;
          cbsc_pkg::st_tx_single_auto: o_next = cbsc_pkg::st_tx_busy_b;
          default:                     o_update = 1'b0;
        endcase
      end
      cbsc_pkg::cmd_remote_match: begin
        o_update = (i_state == cbsc_pkg::st_tx_autoreply);
        if (o_update) begin
          o_next = cbsc_pkg::st_tx_busy_b;
        end
      end
      cbsc_pkg::cmd_tx_done: begin
        o_update = 1'b1;
        case (i_state)
          cbsc_pkg::st_tx_busy_a:    o_next = cbsc_pkg::st_tx_idle;
          cbsc_pkg::st_tx_busy_b:    o_next = cbsc_pkg::st_tx_autoreply;
          cbsc_pkg::st_tx_cancelled: o_next = cbsc_pkg::st_tx_idle;
          default:                   o_update = 1'b0;
        endcase
      end
      default: o_update = 1'b0;
    endcase
  end

endmodule : cbsc_engine_next

/* rtl/cbsc_pkg.sv */
// Constants and types for the buffer status/control word block.
// Assumes one clock domain and single-cycle agents on both sides.
//
// How it works
// - Word layout: length 15:12, reserved 11:8, priority 7:4, state 3:0.
// - CPU and engine both read and write the word; engine wins contention.
// - While busy, only low-byte control word writes are accepted.
// - Engine sets busy during receive copy and pending or active transmission.
// - Engine copy-done and transmit-done updates always leave the busy bit cleared.
// - Receive states: idle 0000, armed 0010, holding 0100, lost 0110.
// - Copy start sets busy: armed 0011, holding 0101, lost 0111.
// - State 0001 only when software writes receive idle during a copy.
// - Transmit: idle 1000, single 1100; busy codes 1101 and 1111.
// - State 1010 answers a matching remote frame automatically.
// - State 1110 transmits once, then becomes 1010.
// - State 1001 only when software writes transmit idle while busy.
// - Encoding 1011 is never produced.
// - Priority field holds software transmit priority used by the engine.
// - On reception the engine writes the length code.
// - Length code is a plain 4-bit binary field, 0 to 15; the byte count it gives runs 0 to 8.
// - Length codes of eight or more mean eight bytes.
// - Bytes beyond the coded length are ignored or may be garbage.
package cbsc_pkg;

  localparam int        DLC_MSB      = 15;
  localparam int        DLC_LSB      = 12;
  localparam int        PRI_MSB      = 7;
  localparam int        PRI_LSB      = 4;
  localparam int        ST_MSB       = 3;
  localparam int        ST_LSB       = 0;
  localparam int        BUSY_BIT     = 0;
  localparam int        DIR_BIT      = 3;
  localparam logic [2:0] CTL_WORD_IDX = 3'h0;
  localparam logic [15:0] CTL_RESET   = 16'h0000;
  localparam logic [3:0] MAX_BYTES    = 4'h8;

  typedef enum logic [3:0] {
    st_rx_idle        = 4'h0,
    st_rx_cancelled   = 4'h1,
    st_rx_armed       = 4'h2,
    st_rx_copy_first  = 4'h3,
    st_rx_holding     = 4'h4,
    st_rx_copy_second = 4'h5,
    st_rx_lost        = 4'h6,
    st_rx_copy_later  = 4'h7,
    st_tx_idle        = 4'h8,
    st_tx_cancelled   = 4'h9,
    st_tx_autoreply   = 4'ha,
    st_reserved       = 4'hb,
    st_tx_single      = 4'hc,
    st_tx_busy_a      = 4'hd,
    st_tx_single_auto = 4'he,
    st_tx_busy_b      = 4'hf
  } cbsc_state_type;

  typedef enum logic [2:0] {
    cmd_none         = 3'h0,
    cmd_copy_start   = 3'h1,
    cmd_copy_done    = 3'h2,
    cmd_tx_schedule  = 3'h3,
    cmd_remote_match = 3'h4,
    cmd_tx_done      = 3'h5
  } cbsc_cmd_type;

endpackage : cbsc_pkg

/* rtl/cbsc_top.sv */
// Status/control word of one message buffer, shared by CPU and CAN engine.
// Assumes the engine and the CPU run on i_ref_clk; the buffer data RAM
// lives outside and is written only through the gated strobe below.
module cbsc_top (
  input  wire logic        i_ref_clk,
  input  wire logic        i_nrst,
  // CPU side
  input  wire logic        i_cpu_req,
  input  wire logic        i_cpu_we,
  input  wire logic [2:0]  i_cpu_addr,
  input  wire logic [1:0]  i_cpu_be,
  input  wire logic [15:0] i_cpu_wdata,
  input  wire logic [15:0] i_data_rdata,
  output logic             o_cpu_ack,
  output logic             o_cpu_reject,
  output logic [15:0]      o_cpu_rdata,
  // Data RAM write strobe, passed on only when the buffer is not busy
  output logic             o_data_we,
  output logic [2:0]       o_data_addr,
  output logic [1:0]       o_data_be,
  output logic [15:0]      o_data_wdata,
  // CAN engine side
  input  wire logic        i_eng_valid,
  input  wire logic [2:0]  i_eng_cmd,
  input  wire logic [3:0]  i_eng_dlc,
  output logic [3:0]       o_buffer_state,
  output logic [3:0]       o_tx_priority,
  output logic [3:0]       o_dlc,
  output logic [3:0]       o_byte_count,
  output logic             o_tx_pending,
  output logic             o_autoreply_armed
);

  ////////////////////////////////////////////////////////////////////////////
  // Arbitration

  cbsc_arb_if arb ();

  assign arb.eng_valid = i_eng_valid;
  assign arb.cpu_req   = i_cpu_req;

  cbsc_arbiter u_arb (
    .i_ref_clk (i_ref_clk),
    .i_nrst    (i_nrst),
    .bus       (arb.arb)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Stored word

  cbsc_pkg::cbsc_state_type state;
  logic [3:0]               prio;
  logic [3:0]               data_length_code;

  cbsc_pkg::cbsc_state_type next_state;
  logic [3:0]               next_prio;
  logic [3:0]               next_dlc;
  logic [3:0]               next_count;

  ////////////////////////////////////////////////////////////////////////////
  // Engine commands

  cbsc_pkg::cbsc_cmd_type   eng_cmd;
  cbsc_pkg::cbsc_state_type eng_next;
  logic                     eng_update;
  logic                     eng_dlc_write;
  logic                     eng_take;

  assign eng_cmd  = cbsc_pkg::cbsc_cmd_type'(i_eng_cmd);
  assign eng_take = arb.eng_grant;

  cbsc_engine_next u_next (
    .i_state     (state),
    .i_cmd       (eng_cmd),
    .o_next      (eng_next),
    .o_update    (eng_update),
    .o_dlc_write (eng_dlc_write)
  );

  ////////////////////////////////////////////////////////////////////////////
  // CPU access decode

  wire busy     = state[cbsc_pkg::BUSY_BIT];
  wire is_tx    = state[cbsc_pkg::DIR_BIT];
  wire cpu_take = arb.cpu_grant;
  wire cpu_wr   = cpu_take & i_cpu_we;
  wire ctl_sel  = (i_cpu_addr == cbsc_pkg::CTL_WORD_IDX);

  // Low byte of the control word is always writable; the rest is not while busy
  wire wr_low   = cpu_wr & ctl_sel & i_cpu_be[0];
  wire wr_high  = cpu_wr & ctl_sel & i_cpu_be[1] & ~busy;
  wire wr_data  = cpu_wr & ~ctl_sel & (|i_cpu_be) & ~busy;
  wire wr_block = cpu_wr & busy & (~ctl_sel | i_cpu_be[1]);

  wire [3:0] wst = i_cpu_wdata[cbsc_pkg::ST_MSB:cbsc_pkg::ST_LSB];
  wire [3:0] wpr = i_cpu_wdata[cbsc_pkg::PRI_MSB:cbsc_pkg::PRI_LSB];
  wire [3:0] wdl = i_cpu_wdata[cbsc_pkg::DLC_MSB:cbsc_pkg::DLC_LSB];

  // Writing idle over a running copy or transmission keeps a busy marker,
  // so the engine can still close out the operation it has started
  wire rx_cancel = (wst == cbsc_pkg::st_rx_idle) & busy & ~is_tx;
  wire tx_cancel = (wst == cbsc_pkg::st_tx_idle) & busy & is_tx;
  // Odd idle codes written directly would fake a busy marker; treat as idle
  wire bad_code  = (wst == cbsc_pkg::st_reserved);

  cbsc_pkg::cbsc_state_type cpu_state;

  always_comb begin
    if (rx_cancel) begin
      cpu_state = cbsc_pkg::st_rx_cancelled;
    end else if (tx_cancel) begin
      cpu_state = cbsc_pkg::st_tx_cancelled;
    end else if (bad_code) begin
      cpu_state = state;
    end else if (wst == cbsc_pkg::st_rx_cancelled) begin
      cpu_state = cbsc_pkg::st_rx_idle;
    end else if (wst == cbsc_pkg::st_tx_cancelled) begin
      cpu_state = cbsc_pkg::st_tx_idle;
    end else begin
      cpu_state = cbsc_pkg::cbsc_state_type'(wst);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next values

  assign next_state = (eng_take & eng_update) ? eng_next :
                      wr_low ? cpu_state : state;
  assign next_prio  = wr_low ? wpr : prio;
  assign next_dlc   = (eng_take & eng_dlc_write) ? i_eng_dlc :
                      wr_high ? wdl : data_length_code;
  // Codes of eight and above all mean eight bytes
  assign next_count = (next_dlc >= cbsc_pkg::MAX_BYTES) ?
                      cbsc_pkg::MAX_BYTES : next_dlc;

  wire [15:0] ctl_word = {data_length_code, 4'h0, prio, state};

  wire next_pending = (next_state == cbsc_pkg::st_tx_busy_a) |
                      (next_state == cbsc_pkg::st_tx_busy_b);
  wire next_auto    = (next_state == cbsc_pkg::st_tx_autoreply) |
                      (next_state == cbsc_pkg::st_tx_single_auto);

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      state <= cbsc_pkg::cbsc_state_type'(cbsc_pkg::CTL_RESET[3:0]);
      prio  <= cbsc_pkg::CTL_RESET[7:4];
      data_length_code   <= cbsc_pkg::CTL_RESET[15:12];
    end else begin
      state <= next_state;
      prio  <= next_prio;
      data_length_code   <= next_dlc;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      o_buffer_state    <= cbsc_pkg::CTL_RESET[3:0];
      o_tx_priority     <= cbsc_pkg::CTL_RESET[7:4];
      o_dlc             <= cbsc_pkg::CTL_RESET[15:12];
      o_byte_count      <= cbsc_pkg::CTL_RESET[15:12];
      o_tx_pending      <= 1'b0;
      o_autoreply_armed <= 1'b0;
    end else begin
      o_buffer_state    <= next_state;
      o_tx_priority     <= next_prio;
      o_dlc             <= next_dlc;
      o_byte_count      <= next_count;
      o_tx_pending      <= next_pending;
      o_autoreply_armed <= next_auto;
    end
  end

  // Read data shows the word as it stood when the access was granted
  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      o_cpu_ack    <= 1'b0;
      o_cpu_reject <= 1'b0;
      o_cpu_rdata  <= 16'h0000;
    end else begin
      o_cpu_ack    <= cpu_take;
      o_cpu_reject <= wr_block;
      if (cpu_take) begin
        o_cpu_rdata <= ctl_sel ? ctl_word : i_data_rdata;
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      o_data_we    <= 1'b0;
      o_data_addr  <= 3'h0;
      o_data_be    <= 2'h0;
      o_data_wdata <= 16'h0000;
    end else begin
      o_data_we <= wr_data;
      if (wr_data) begin
        o_data_addr  <= i_cpu_addr;
        o_data_be    <= i_cpu_be;
        o_data_wdata <= i_cpu_wdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_nrst);

  wire eng_cmd_is_start = eng_take & (eng_cmd == cbsc_pkg::cmd_copy_start);
  wire eng_cmd_is_done  = eng_take & (eng_cmd == cbsc_pkg::cmd_copy_done);
  wire eng_cmd_is_sched = eng_take & (eng_cmd == cbsc_pkg::cmd_tx_schedule);
  wire eng_cmd_is_txend = eng_take & (eng_cmd == cbsc_pkg::cmd_tx_done);

  sequence s_single_auto_sched;
    (state == cbsc_pkg::st_tx_single_auto) && eng_cmd_is_sched;
  endsequence

  sequence s_tx_finish;
    eng_cmd_is_txend && (state == cbsc_pkg::st_tx_busy_b);
  endsequence

  a_no_reserved_code: assert property (
    o_buffer_state != 4'hb
  ) else $error("Reserved buffer state produced");

  a_busy_blocks_data: assert property (
    (cpu_wr && busy && !ctl_sel) |=> (!o_data_we && o_cpu_reject && o_cpu_ack)
  ) else $error("Data write passed while buffer busy");

  a_low_byte_open: assert property (
    wr_low |=> (o_tx_priority == $past(wpr))
  ) else $error("Low byte write lost");

  a_copy_sets_busy: assert property (
    (eng_cmd_is_start && state == cbsc_pkg::st_rx_lost)
      |=> (o_buffer_state == 4'h7) && o_buffer_state[0]
  ) else $error("Copy start did not mark busy");

  a_copy_end_state: assert property (
    (eng_cmd_is_done && state == cbsc_pkg::st_rx_copy_first)
      |=> (o_buffer_state == 4'h4) && (o_dlc == $past(i_eng_dlc))
  ) else $error("Copy end state or length wrong");

  a_status_clears: assert property (
    (eng_cmd_is_done || eng_cmd_is_txend) && eng_update |=> !o_buffer_state[0]
  ) else $error("Engine update left busy set");

  a_rx_cancel_mark: assert property (
    (wr_low && !eng_take && wst == 4'h0 && busy && !is_tx)
      |=> o_buffer_state == 4'h1
  ) else $error("Receive cancel marker missing");

  a_tx_cancel_mark: assert property (
    (wr_low && !eng_take && wst == 4'h8 && state == cbsc_pkg::st_tx_busy_a)
      |=> o_buffer_state == 4'h9 ##1 !o_tx_pending
  ) else $error("Transmit cancel marker missing");

  a_single_then_auto: assert property (
    s_single_auto_sched ##[1:8] s_tx_finish |=> (o_buffer_state == 4'ha) && o_autoreply_armed
  ) else $error("Single then autoreply did not settle");

  a_single_done_idle: assert property (
    (eng_cmd_is_txend && state == cbsc_pkg::st_tx_busy_a)
      |=> (o_buffer_state == 4'h8) && !o_tx_pending
  ) else $error("Single shot did not return to idle");

  a_count_clamped: assert property (
    o_byte_count == ((o_dlc >= 4'h8) ? 4'h8 : o_dlc)
  ) else $error("Byte count not clamped to eight");

  a_engine_first: assert property (
    (i_eng_valid && i_cpu_req) |=> !o_cpu_ack
  ) else $error("CPU granted against engine");

  a_sched_sets_busy: assert property (
    (eng_cmd_is_sched && state == cbsc_pkg::st_tx_single)
      |=> (o_buffer_state == 4'hd) && o_tx_pending
  ) else $error("Schedule did not mark busy");

  a_high_byte_guard: assert property (
    (cpu_wr && busy && ctl_sel && i_cpu_be[1]) |=> o_cpu_reject && $stable(o_dlc)
  ) else $error("High byte written while busy");

  a_remote_answer: assert property (
    (eng_take && eng_cmd == cbsc_pkg::cmd_remote_match && state == cbsc_pkg::st_tx_autoreply)
      |=> (o_buffer_state == 4'hf) && o_tx_pending
  ) else $error("Remote match did not start an answer");

  a_pending_flag: assert property (
    o_tx_pending == ((o_buffer_state == 4'hd) || (o_buffer_state == 4'hf))
  ) else $error("Pending flag does not follow state");

  // Even receive codes written to an idle buffer are stored as given
  a_rx_code_stored: assert property (
    (wr_low && !busy && !wst[3] && !wst[0]) |=> (o_buffer_state == $past(wst))
  ) else $error("Receive state code not stored");

  a_tx_mark_to_idle: assert property (
    (wr_low && !busy && wst == 4'h9) |=> (o_buffer_state == 4'h8)
  ) else $error("Direct transmit marker write not idled");

  a_reserved_write: assert property (
    (wr_low && wst == 4'hb) |=> (o_buffer_state == $past(state))
  ) else $error("Reserved code write changed state");

endmodule : cbsc_top

/* tb/can_buffer_status_control_tb.sv */
// Self-checking bench for the buffer status/control word.
// Assumes cbsc_top with registered CPU answers and one-cycle engine commands.
module can_buffer_status_control_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        cpu_req = 1'b0, cpu_we = 1'b0;
  logic [2:0]  cpu_addr = 3'h0;
  logic [1:0]  cpu_be = 2'h0;
  logic [15:0] cpu_wdata = 16'h0000, rd, we_data;
  logic        rj;
  wire  [15:0] data_rdata = 16'ha5c0 ^ {13'h0000, cpu_addr};
  wire         ack, rej, dwe, evld, pend, armd;
  wire  [15:0] rdat, dwd;
  wire  [2:0]  dadr, ecmd;
  wire  [1:0]  dbe;
  wire  [3:0]  edlc, st, tx_priority_code, data_length_code, bcnt;
  int          err_count = 0, cmp_count = 0, cyc = 0, we_cnt = 0;
  logic [2:0]  we_addr;
  logic [1:0]  we_be;

  always #4 clk = ~clk;

  cbsc_eng_model u_eng (.i_ref_clk(clk), .o_eng_valid(evld), .o_eng_cmd(ecmd),
                        .o_eng_dlc(edlc));

  cbsc_top u_dut (.i_ref_clk(clk), .i_nrst(nrst), .i_cpu_req(cpu_req), .i_cpu_we(cpu_we),
    .i_cpu_addr(cpu_addr), .i_cpu_be(cpu_be), .i_cpu_wdata(cpu_wdata),
    .i_data_rdata(data_rdata), .o_cpu_ack(ack), .o_cpu_reject(rej), .o_cpu_rdata(rdat),
    .o_data_we(dwe), .o_data_addr(dadr), .o_data_be(dbe), .o_data_wdata(dwd),
    .i_eng_valid(evld), .i_eng_cmd(ecmd), .i_eng_dlc(edlc), .o_buffer_state(st),
    .o_tx_priority(tx_priority_code), .o_dlc(data_length_code), .o_byte_count(bcnt), .o_tx_pending(pend),
    .o_autoreply_armed(armd));

  ////////////////////////////////////////////////////////////////////////////
  always @(negedge clk) begin
    if (dwe === 1'b1) begin
      we_cnt  <= we_cnt + 1;
      we_addr <= dadr;
      we_data <= dwd;
      we_be   <= dbe;
    end
  end

  task automatic give_verdict();
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : give_verdict

  // Ceiling is over sixty times the length of the scripted sequence
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_count = err_count + 1;
      give_verdict();
    end
  end

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic chk_flag(input string nm, input logic e, input logic g);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %b seen %b", nm, e, g);
    end
  endtask : chk_flag

  task automatic st_is(input logic [3:0] e);
    chk("buffer_state", {12'h000, e}, {12'h000, st});
  endtask : st_is

  // Request held until ack, dropped in the ack cycle, then one idle cycle
  task automatic cpu(input logic we, input logic [2:0] a, input logic [1:0] be,
                     input logic [15:0] d);
    int n = 0;
    cpu_req   = 1'b1;
    cpu_we    = we;
    cpu_addr  = a;
    cpu_be    = be;
    cpu_wdata = d;
    @(negedge clk);
    while (ack !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    chk_flag("cpu_ack", 1'b1, ack);
    rd        = rdat;
    rj        = rej;
    cpu_req   = 1'b0;
    cpu_we    = 1'b0;
    cpu_addr  = ~a;
    cpu_wdata = ~d;
    @(negedge clk);
  endtask : cpu

  task automatic eng(input logic [2:0] c, input logic [3:0] d);
    u_eng.send(c, d, 0);
  endtask : eng

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(negedge clk);
    nrst = 1'b1;
    @(negedge clk);
    cpu(1'b0, 3'h0, 2'h3, 16'h0000);
    chk("reset word", 16'h0000, rd);
    cpu(1'b1, 3'h0, 2'h3, 16'h3f52);
    cpu(1'b0, 3'h0, 2'h3, 16'h0000);
    chk("word layout", 16'h3052, rd);
    chk("dlc", 16'h0003, {12'h000, data_length_code});
    chk("priority", 16'h0005, {12'h000, tx_priority_code});
    $display("test layout done");
    eng(3'h1, 4'h0);
    st_is(4'h3);
    u_eng.send(3'h2, 4'h5, 2);
    st_is(4'h4);
    chk("rx length", 16'h0505, {4'h0, data_length_code, 4'h0, bcnt});
    eng(3'h1, 4'h0);
    st_is(4'h5);
    eng(3'h2, 4'hc);
    st_is(4'h6);
    chk("byte count", 16'h0008, {12'h000, bcnt});
    eng(3'h1, 4'h0);
    st_is(4'h7);
    cpu(1'b1, 3'h1, 2'h3, 16'h1234);
    chk_flag("data word reject", 1'b1, rj);
    chk("ram writes", 16'h0000, we_cnt[15:0]);
    cpu(1'b1, 3'h0, 2'h2, 16'h9900);
    chk_flag("high byte reject", 1'b1, rj);
    chk("dlc kept", 16'h000c, {12'h000, data_length_code});
    cpu(1'b1, 3'h0, 2'h1, 16'h0000);
    st_is(4'h1);
    eng(3'h2, 4'h6);
    st_is(4'h0);
    $display("test receive done");
    cpu(1'b1, 3'h1, 2'h3, 16'h1234);
    chk("ram write", 16'h1234, we_data);
    chk("ram write addr be", 16'h0019, {11'h000, we_be, we_addr});
    chk("ram writes", 16'h0001, we_cnt[15:0]);
    cpu(1'b0, 3'h5, 2'h3, 16'h0000);
    chk("ram read", 16'ha5c5, rd);
    $display("test data words done");
    cpu(1'b1, 3'h0, 2'h3, 16'h704c);
    chk("tx setup", 16'h0074, {8'h00, data_length_code, tx_priority_code});
    eng(3'h3, 4'h0);
    st_is(4'hd);
    chk_flag("tx pending", 1'b1, pend);
    cpu(1'b1, 3'h2, 2'h3, 16'h5555);
    chk_flag("busy reject", 1'b1, rj);
    cpu(1'b1, 3'h0, 2'h1, 16'h0048);
    st_is(4'h9);
    eng(3'h5, 4'h0);
    st_is(4'h8);
    cpu(1'b1, 3'h0, 2'h1, 16'h004c);
    eng(3'h3, 4'h0);
    eng(3'h5, 4'h0);
    st_is(4'h8);
    chk_flag("tx pending", 1'b0, pend);
    $display("test transmit done");
    cpu(1'b1, 3'h0, 2'h1, 16'h004e);
    chk_flag("autoreply", 1'b1, armd);
    eng(3'h3, 4'h0);
    st_is(4'hf);
    eng(3'h5, 4'h0);
    st_is(4'ha);
    eng(3'h4, 4'h0);
    st_is(4'hf);
    eng(3'h5, 4'h0);
    st_is(4'ha);
    $display("test autoreply done");
    cpu(1'b1, 3'h0, 2'h1, 16'h004b);
    st_is(4'ha);
    cpu(1'b1, 3'h0, 2'h1, 16'h0049);
    st_is(4'h8);
    cpu(1'b1, 3'h0, 2'h1, 16'h0041);
    st_is(4'h0);
    eng(3'h1, 4'h0);
    st_is(4'h0);
    $display("test odd codes done");
    cpu(1'b1, 3'h0, 2'h1, 16'h004c);
    fork
      eng(3'h3, 4'h0);
      cpu(1'b1, 3'h4, 2'h3, 16'hbeef);
    join
    chk_flag("contention reject", 1'b1, rj);
    st_is(4'hd);
    chk("ram writes", 16'h0001, we_cnt[15:0]);
    $display("test contention done");
    give_verdict();
  end
endmodule : can_buffer_status_control_tb

/* tb/cbsc_eng_model.sv */
// Behavioural protocol engine that issues state commands to one buffer.
// Assumes it shares i_ref_clk with the design and drives on falling edges.
module cbsc_eng_model (
  input  wire logic  i_ref_clk,
  output logic       o_eng_valid,
  output logic [2:0] o_eng_cmd,
  output logic [3:0] o_eng_dlc
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    o_eng_valid = 1'b0;
    o_eng_cmd   = 3'h0;
    o_eng_dlc   = 4'h0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // One command pulse, after an optional lag to mimic a slow engine
  task automatic send(input logic [2:0] cmd, input logic [3:0] data_length_code, input int lag);
    repeat (lag) @(negedge i_ref_clk);
    o_eng_valid = 1'b1;
    o_eng_cmd   = cmd;
    o_eng_dlc   = data_length_code;
    @(negedge i_ref_clk);
    // Qualifiers are scrambled once invalid so a stale value never looks valid
    o_eng_valid = 1'b0;
    o_eng_cmd   = ~cmd;
    o_eng_dlc   = ~data_length_code;
    @(negedge i_ref_clk);
  endtask : send
endmodule : cbsc_eng_model
